// ---- bench/sfdl_asserts.sv ----
// Checker for the serial four-digit LED driver outputs
`timescale 1ns/100ps
module sfdl_asserts #(
  parameter OSC_HALF = 2500
) (
  input wire       clk_in,
  input wire       rst_b_in,
  input wire       sclk_in,
  input wire       sdata_in,
  input wire       load_b_in,
  input wire       ext_osc_sel_in,
  input wire       ext_osc_in,
  input wire [6:0] seg_out,
  input wire       dp_out,
  input wire [3:0] digit_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_oh; $past(rst_b_in) |-> $onehot(digit_out); endproperty
  a_oh: assert property (p_oh) else $error("strobe not one-hot");
  property p_rot; $changed(digit_out) && $past(digit_out) != 0 |-> digit_out == $past(digit_out) * 2 % 15; endproperty
  a_rot: assert property (p_rot) else $error("strobe order");
  property p_slot; $changed(digit_out) |=> $stable(digit_out) [*3]; endproperty
  a_slot: assert property (p_slot) else $error("slot too short");
  property p_int; OSC_HALF <= 4 && !ext_osc_sel_in && $changed(digit_out) |-> ##[1:12] ($changed(digit_out) || ext_osc_sel_in); endproperty
  a_int: assert property (p_int) else $error("scan stalled");
  property p_ext; ext_osc_sel_in && $rose(ext_osc_in) |-> ##[1:8] $changed(digit_out); endproperty
  a_ext: assert property (p_ext) else $error("external scan ignored");
  property p_idle; load_b_in && $past(load_b_in, 6) && digit_out == $past(digit_out, 2) |-> $stable(seg_out) && $stable(dp_out); endproperty
  a_idle: assert property (p_idle) else $error("output moved while gate high");
  property p_hold; !load_b_in && !$past(load_b_in, 6) && digit_out == $past(digit_out, 2) |-> $stable(seg_out); endproperty
  a_hold: assert property (p_hold) else $error("display moved while shifting");
  property p_seg; $past(rst_b_in) |-> seg_out inside {7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h39, 7'h5e, 7'h79, 7'h40, 7'h00}; endproperty
  a_seg: assert property (p_seg) else $error("segment pattern");
  c_wrap: cover property ($rose(digit_out[3]));
  c_load: cover property ($rose(load_b_in));
  c_ext: cover property (ext_osc_sel_in && $changed(digit_out));
endmodule // sfdl_asserts
bind sfdl_driver sfdl_asserts #(.OSC_HALF(OSC_HALF)) u_sfdl_asserts (.clk_in, .rst_b_in, .sclk_in,
  .sdata_in, .load_b_in, .ext_osc_sel_in, .ext_osc_in, .seg_out, .dp_out, .digit_out);

// ---- bench/sfdl_host.sv ----
// Controller model that shifts words into the display driver
`timescale 1ns/100ps
module sfdl_host (
  input  wire  clk_in,
  output logic sclk_out = 1'b0,
  output logic sdata_out = 1'b0,
  output logic load_b_out = 1'b1
);
  // Five clocks per level, since the receiver needs three to see one
  task automatic step(input logic s);
    repeat (5) @(posedge clk_in);
    #1 sclk_out = s;
  endtask
  task automatic send(input logic [19:0] w, input int n, input bit latch);
    load_b_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      step(1'b0);
      sdata_out = w[i];
      step(1'b1);
      step(1'b0);
    end
    step(1'b0);
    load_b_out = latch;
    sdata_out = !sdata_out;
    step(1'b0);
    step(1'b0);
  endtask
endmodule // sfdl_host

// ---- bench/testbench.sv ----
// Self-checking bench for the serial four-digit LED driver
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       ext_osc_sel_in = 1'b0;
  logic       ext_osc_in = 1'b0;
  wire        sclk_in, sdata_in, load_b_in, dp_out;
  wire  [6:0] seg_out;
  wire  [3:0] digit_out;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  logic [6:0] tab [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                           7'h7f, 7'h6f, 7'h77, 7'h39, 7'h5e, 7'h79, 7'h40, 7'h00};
  sfdl_host u_sfdl_host (.clk_in, .sclk_out(sclk_in), .sdata_out(sdata_in), .load_b_out(load_b_in));
  sfdl_driver #(.OSC_HALF(4)) u_sfdl_driver (.clk_in, .rst_b_in, .sclk_in, .sdata_in, .load_b_in,
    .ext_osc_sel_in, .ext_osc_in, .seg_out, .dp_out, .digit_out);
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cyc > 30000) begin n_errors++; print_verdict(); end
  task automatic print_verdict;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic show(input logic [19:0] w);
    wait (digit_out === 4'h8);
    for (int k = 0; k < 4; k++) begin
      wait (digit_out === 4'h1 << k);
      @(posedge clk_in) #1;
      `CHK(seg_out, tab[w[15-4*k -: 4]])
      `CHK(dp_out, w[19-k])
    end
  endtask
  task automatic t_codes;
    u_sfdl_host.send(20'h50123, 20, 1);
    show(20'h50123);
    u_sfdl_host.send(20'ha4567, 20, 1);
    show(20'ha4567);
    u_sfdl_host.send(20'h089ab, 16, 1);
    show(20'h789ab);
    u_sfdl_host.send(20'h3cdef, 20, 1);
    show(20'h3cdef);
  endtask
  task automatic t_cascade;
    u_sfdl_host.send(20'hf1234, 20, 1);
    `CHK(dp_out, 1'b1)
    u_sfdl_host.send(20'h00000, 5, 0);
    `CHK(dp_out, 1'b0)
    u_sfdl_host.send(20'h00000, 20, 1);
    show(20'h00000);
  endtask
  task automatic t_ext;
    logic [3:0] d0;
    ext_osc_sel_in = 1'b1;
    repeat (12) @(posedge clk_in);
    #1 d0 = digit_out;
    repeat (12) begin
      repeat (500) @(posedge clk_in);
      #1 ext_osc_in = !ext_osc_in;
    end
    repeat (10) @(posedge clk_in);
    #1 `CHK(digit_out, {d0[1:0], d0[3:2]})
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    t_codes();
    t_cascade();
    t_ext();
    print_verdict();
  end
endmodule // testbench

// ---- core/sfdl_driver.v ----
// Serial four-digit multiplexed seven-segment driver core
`timescale 1ns/100ps
`include "sfdl_regs.vh"
module sfdl_driver #(
  parameter         OSC_HALF  = `SFDL_OSC_HALF,
  // Patterns {g..a}, seven bits per code, code 0 in the top field
  parameter [111:0] SEG_TABLE = {
    `SFDL_SEG_0, `SFDL_SEG_1, `SFDL_SEG_2, `SFDL_SEG_3,
    `SFDL_SEG_4, `SFDL_SEG_5, `SFDL_SEG_6, `SFDL_SEG_7,
    `SFDL_SEG_8, `SFDL_SEG_9, `SFDL_SEG_A, `SFDL_SEG_B,
    `SFDL_SEG_C, `SFDL_SEG_D, `SFDL_SEG_E, `SFDL_SEG_F
  }
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_b_in,
  // Serial port pins
  input  wire       sclk_in,
  input  wire       sdata_in,
  input  wire       load_b_in,
  // Scan clock source
  input  wire       ext_osc_sel_in,
  input  wire       ext_osc_in,
  // Display outputs
  output reg  [6:0] seg_out,
  output reg        dp_out,
  output reg  [3:0] digit_out
);

  // ==========================================================
  // Sizes taken from the shared constants
  localparam WORD_BITS = `SFDL_WORD_BITS;
  localparam NIB_BITS  = `SFDL_NIB_BITS;
  localparam DIGITS    = `SFDL_DIGITS;
  localparam SEG_BITS  = `SFDL_SEG_BITS;
  localparam CODES     = `SFDL_CODES;
  localparam SCAN_BITS = `SFDL_SCAN_BITS;
  localparam DP_MSB    = `SFDL_DP_MSB;
  localparam DP_LSB    = `SFDL_DP_LSB;
  // Widened once so that a part-select of it is legal
  localparam [31:0] OSC_HALF_W = OSC_HALF;

  // ==========================================================
  // Input synchronisers
  // Every pin passes two flops before any logic reads it. The extra
  // flop on edge-carrying pins only remembers the settled level. Reset
  // levels match the idle level of each pin, so no false edge follows.
  reg [1:0] sclk_sync_reg;
  reg [1:0] sdata_sync_reg;
  reg [1:0] load_sync_reg;
  reg [1:0] osc_sync_reg;
  reg [1:0] sel_sync_reg;
  reg       sclk_d_reg;
  reg       load_d_reg;
  reg       osc_d_reg;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_sync_reg <= `SFDL_SYNC_LO;
      sclk_d_reg    <= `SFDL_PIN_LO;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sdata_sync_reg <= `SFDL_SYNC_LO;
    end else begin
      sdata_sync_reg <= {sdata_sync_reg[0], sdata_in};
    end
  end

  // Gate idles high, so its chain resets high
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      load_sync_reg <= `SFDL_SYNC_HI;
      load_d_reg    <= `SFDL_PIN_HI;
    end else begin
      load_sync_reg <= {load_sync_reg[0], load_b_in};
      load_d_reg    <= load_sync_reg[1];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_sync_reg <= `SFDL_SYNC_LO;
      osc_d_reg    <= `SFDL_PIN_LO;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], ext_osc_in};
      osc_d_reg    <= osc_sync_reg[1];
    end
  end

  // Source select is a strap, but may be moved at any time
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_sync_reg <= `SFDL_SYNC_LO;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], ext_osc_sel_in};
    end
  end

  wire sclk_fall = sclk_d_reg & ~sclk_sync_reg[1];
  wire load_rise = ~load_d_reg & load_sync_reg[1];
  wire gate_open = ~load_sync_reg[1];
  wire osc_rise  = osc_sync_reg[1] & ~osc_d_reg;
  wire ext_sel   = sel_sync_reg[1];

  // ==========================================================
  // Shift register and display latches
  reg [WORD_BITS-1:0] shift_reg;
  reg [WORD_BITS-1:0] latch_reg;

  // Earliest bit ends at the top, so the dp nibble lands high
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_reg <= `SFDL_RST_WORD;
    end else if (gate_open && sclk_fall) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], sdata_sync_reg[1]};
    end
  end

  // A 16-bit load moves the old lowest nibble up into the dp bits above the new digits
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_reg <= `SFDL_RST_WORD;
    end else if (load_rise) begin
      latch_reg <= shift_reg;
    end
  end

  // Bit that leaves the register next feeds a chained device
  wire serial_out = shift_reg[WORD_BITS-1];

  // ==========================================================
  // Scan oscillator and divide-by-four
  // The internal oscillator stands in for the capacitor-timed one;
  // its rate is a parameter, since no capacitor exists on chip.
  reg  [15:0]          osc_cnt_reg;
  reg                  int_osc_reg;
  reg  [SCAN_BITS-1:0] scan_reg;
  wire [15:0]          osc_last  = OSC_HALF_W[15:0] - `SFDL_CNT_STEP;
  wire                 int_tick  = (osc_cnt_reg == osc_last);
  wire                 int_rise  = int_tick & ~int_osc_reg;
  wire                 scan_tick = ext_sel ? osc_rise : int_rise;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_cnt_reg <= `SFDL_RST_CNT;
      int_osc_reg <= `SFDL_PIN_LO;
    end else if (int_tick) begin
      osc_cnt_reg <= `SFDL_RST_CNT;
      int_osc_reg <= ~int_osc_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + `SFDL_CNT_STEP;
    end
  end

  // One step per scan tick, so each digit owns a quarter
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scan_reg <= `SFDL_RST_SCAN;
    end else if (scan_tick) begin
      scan_reg <= scan_reg + `SFDL_SCAN_STEP;
    end
  end

  wire [31:0] scan_wide = {{(32-SCAN_BITS){1'h0}}, scan_reg};

  // ==========================================================
  // Per-digit fields and strobes
  // Digit 0 was shifted in first, so its nibble sits highest.
  wire [DIGITS*NIB_BITS-1:0] dig_codes;
  wire [DIGITS-1:0]          dig_dps;
  wire [DIGITS-1:0]          strobe_next;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g = g + 1) begin : g_digit
      assign dig_codes[g*NIB_BITS +: NIB_BITS] = latch_reg[DP_LSB-1-NIB_BITS*g -: NIB_BITS];
      assign dig_dps[g]     = latch_reg[DP_MSB-g];
      assign strobe_next[g] = (scan_wide == g);
    end
  endgenerate

  // ==========================================================
  // Digit select
  reg  [NIB_BITS-1:0] code_sel;
  reg                 dp_sel;
  wire                cascade = (latch_reg[DP_MSB:DP_LSB] == `SFDL_CASCADE_PAT);

  always @* begin
    code_sel = dig_codes[scan_wide*NIB_BITS +: NIB_BITS];
    dp_sel   = dig_dps[scan_wide];
  end

  // ==========================================================
  // Registered outputs
  // Strobe, segments and dp leave on the same edge, so a digit never
  // shows a neighbour's pattern.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      digit_out <= `SFDL_RST_DIGIT;
      seg_out   <= `SFDL_RST_SEG;
      dp_out    <= `SFDL_PIN_LO;
    end else begin
      digit_out <= strobe_next;
      seg_out   <= SEG_TABLE[SEG_BITS*(CODES-1-code_sel) +: SEG_BITS];
      // Cascade mode hands serial output to the next device
      dp_out    <= cascade ? serial_out : dp_sel;
    end
  end

endmodule // sfdl_driver

// ---- core/sfdl_regs.vh ----
// Constants for the serial four-digit LED driver
`ifndef SFDL_REGS_VH
`define SFDL_REGS_VH
`define SFDL_WORD_BITS   20
`define SFDL_DP_MSB      19
`define SFDL_DP_LSB      16
`define SFDL_NIB_BITS    4
`define SFDL_DIGITS      4
`define SFDL_SEG_BITS    7
`define SFDL_CODES       16
`define SFDL_SCAN_BITS   2
`define SFDL_CASCADE_PAT 4'hf
`define SFDL_RST_WORD    20'h00000
`define SFDL_RST_SEG     7'h00
`define SFDL_RST_DIGIT   4'h0
`define SFDL_RST_SCAN    2'h0
`define SFDL_RST_CNT     16'h0000
`define SFDL_PIN_LO      1'h0
`define SFDL_PIN_HI      1'h1
`define SFDL_SYNC_LO     2'h0
`define SFDL_SYNC_HI     2'h3
`define SFDL_CNT_STEP    16'h0001
`define SFDL_SCAN_STEP   2'h1
`define SFDL_OSC_HALF    16'h09c4
// Segment patterns {g..a}; codes a to f show A, C, d, E, dash, blank
`define SFDL_SEG_0       7'h3f
`define SFDL_SEG_1       7'h06
`define SFDL_SEG_2       7'h5b
`define SFDL_SEG_3       7'h4f
`define SFDL_SEG_4       7'h66
`define SFDL_SEG_5       7'h6d
`define SFDL_SEG_6       7'h7d
`define SFDL_SEG_7       7'h07
`define SFDL_SEG_8       7'h7f
`define SFDL_SEG_9       7'h6f
`define SFDL_SEG_A       7'h77
`define SFDL_SEG_B       7'h39
`define SFDL_SEG_C       7'h5e
`define SFDL_SEG_D       7'h79
`define SFDL_SEG_E       7'h40
`define SFDL_SEG_F       7'h00
`endif
